// ### dp_pkg.sv
// Summary of operation
// - literal add: accumulator plus eight-bit literal into accumulator; carry, half carry, zero
// - register add: accumulator plus file register; destination bit picks accumulator or file
// - literal and: accumulator and literal into accumulator; only zero flag changes
// - register and: accumulator and file register to chosen destination; zero flag only
// - bit clear: selected file bit forced low, others and flags untouched
// - bit set: selected file bit forced high, others and flags untouched
// - skip if clear: bit low discards next instruction, a no-operation runs instead
// - skip if set: bit high discards next instruction, a no-operation runs instead
// - bit tests only read the file register; no flag or register changes
// - read-modify-write on the port register takes its operand from pin levels
// - a successful test costs two cycles, the second being a no-operation
// - an instruction writing the timer zero count clears the prescaler when assigned to it; a bus write through the data window does not
package dp_pkg;

  // ****************************************
  // bus map
  // ****************************************
  localparam logic [7:0] OFS_INSTR  = 8'h00;  // write issues an instruction
  localparam logic [7:0] OFS_ACC    = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_FADDR  = 8'h0C;
  localparam logic [7:0] OFS_FDATA  = 8'h10;
  localparam logic [7:0] OFS_CFG    = 8'h14;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic       HRESP_OKAY    = 1'b0;

  // status and config fields
  localparam int ST_CARRY = 0;
  localparam int ST_HALF  = 1;
  localparam int ST_ZERO  = 2;
  localparam int ST_SKIP  = 3;
  localparam int CFG_PRESC_TMR = 0;
  localparam logic [7:0] RST_BYTE = 8'h00;

  // ****************************************
  // instruction word
  // ****************************************
  localparam int OPC_W    = 14;
  localparam int DEST_POS = 7;
  localparam int BIDX_MSB = 9;
  localparam int BIDX_LSB = 7;
  localparam int FADR_MSB = 6;
  localparam logic [4:0] PAT_LIT_ADD = 5'h1F;  // opcode[13:9]
  localparam logic [5:0] PAT_LIT_AND = 6'h39;  // opcode[13:8]
  localparam logic [5:0] PAT_REG_ADD = 6'h07;
  localparam logic [5:0] PAT_REG_AND = 6'h05;
  localparam logic [3:0] PAT_BCLR    = 4'h4;   // opcode[13:10]
  localparam logic [3:0] PAT_BSET    = 4'h5;
  localparam logic [3:0] PAT_SCLR    = 4'h6;
  localparam logic [3:0] PAT_SSET    = 4'h7;

  // one-hot kind vector positions
  localparam int K_LIT_ADD = 0;
  localparam int K_LIT_AND = 1;
  localparam int K_REG_ADD = 2;
  localparam int K_REG_AND = 3;
  localparam int K_BCLR    = 4;
  localparam int K_BSET    = 5;
  localparam int K_SCLR    = 6;
  localparam int K_SSET    = 7;

  // file addresses of the port latch and the timer zero count
  localparam logic [6:0] PORT_ADDR  = 7'h05;
  localparam logic [6:0] TIMER_ADDR = 7'h01;
  localparam int FILE_DEPTH = 128;

  // single-bit mask from a bit index
  function automatic logic [7:0] bit_mask(input logic [2:0] idx);
    bit_mask = 8'h01 << idx;
  endfunction : bit_mask

endpackage : dp_pkg

// ### alu_if.sv
`timescale 1ns/1ns
// ****************************************
// datapath to alu carrier
// ****************************************
interface alu_if;
  logic [13:0] opcode;
  logic [7:0]  acc;
  logic [7:0]  operand;
  logic [7:0]  result;
  logic [7:0]  kind;
  logic        carry;
  logic        half_carry;
  logic        zero;
  logic        upd_cz;
  logic        upd_z;
  logic        to_acc;
  logic        to_file;
  logic        bit_value;
  logic        skip_taken;

  modport core (output opcode, acc, operand,
                input  result, kind, carry, half_carry, zero, upd_cz, upd_z,
                       to_acc, to_file, bit_value, skip_taken);
  modport alu  (input  opcode, acc, operand,
                output result, kind, carry, half_carry, zero, upd_cz, upd_z,
                       to_acc, to_file, bit_value, skip_taken);
endinterface : alu_if

// ### add_and_alu.sv
`timescale 1ns/1ns
module add_and_alu
  import dp_pkg::*;
(
  alu_if.alu a  // operands in, result and controls out
);

  // ****************************************
  // decode
  // ****************************************
  wire       lit_add = a.opcode[13:9] == PAT_LIT_ADD;
  wire       lit_and = a.opcode[13:8] == PAT_LIT_AND;
  wire       reg_add = a.opcode[13:8] == PAT_REG_ADD;
  wire       reg_and = a.opcode[13:8] == PAT_REG_AND;
  wire       bclr    = a.opcode[13:10] == PAT_BCLR;
  wire       bset    = a.opcode[13:10] == PAT_BSET;
  wire       sclr    = a.opcode[13:10] == PAT_SCLR;
  wire       sset    = a.opcode[13:10] == PAT_SSET;
  wire       dest    = a.opcode[DEST_POS];
  wire [2:0] bidx    = a.opcode[BIDX_MSB:BIDX_LSB];
  wire [7:0] mask    = bit_mask(bidx);

  // ****************************************
  // arithmetic
  // ****************************************
  // literal ops take the low byte, file ops the fetched operand
  wire [7:0] rhs   = (lit_add | lit_and) ? a.opcode[7:0] : a.operand;
  wire [8:0] sum9  = {1'b0, a.acc} + {1'b0, rhs};
  wire [4:0] nib5  = {1'b0, a.acc[3:0]} + {1'b0, rhs[3:0]};
  wire [7:0] andv  = a.acc & rhs;

  assign a.kind       = {sset, sclr, bset, bclr, reg_and, reg_add, lit_and, lit_add};
  assign a.result     = (lit_add | reg_add) ? sum9[7:0] :
                        (lit_and | reg_and) ? andv :
                        bset ? (a.operand | mask) :
                               (a.operand & ~mask);
  assign a.carry      = sum9[8];
  assign a.half_carry = nib5[4];
  assign a.zero       = a.result == RST_BYTE;
  // bit ops and tests never touch flags
  assign a.upd_cz     = lit_add | reg_add;
  assign a.upd_z      = lit_add | reg_add | lit_and | reg_and;
  assign a.to_acc     = lit_add | lit_and | ((reg_add | reg_and) & ~dest);
  assign a.to_file    = ((reg_add | reg_and) & dest) | bclr | bset;
  assign a.bit_value  = a.operand[bidx];
  assign a.skip_taken = (sclr & ~a.bit_value) | (sset & a.bit_value);

endmodule : add_and_alu

// ### add_and_bit_ops_datapath.sv
// The AHB-Lite slave port and the register offsets were left to the implementer.
`timescale 1ns/1ns
module add_and_bit_ops_datapath
  import dp_pkg::*;
(
  input  wire logic        i_clk_sys,        // 50 MHz core clock
  input  wire logic        i_arst_n,         // async reset, low active
  input  wire logic        i_hsel,           // slave select
  input  wire logic [31:0] i_haddr,          // byte address
  input  wire logic [1:0]  i_htrans,         // transfer type
  input  wire logic        i_hwrite,         // write when high
  input  wire logic [2:0]  i_hsize,          // word only
  input  wire logic [31:0] i_hwdata,         // write data
  input  wire logic        i_hready,         // bus ready
  output logic      [31:0] o_hrdata,         // read data
  output logic             o_hreadyout,      // slave ready
  output logic             o_hresp,          // always okay
  input  wire logic [7:0]  i_port_pins,      // port pin levels
  output logic      [7:0]  o_port_latch,     // port output latch
  output logic             o_prescaler_clr,  // one-cycle prescaler clear
  output logic             o_skip_pending    // next instruction discarded
);

  // ****************************************
  // state
  // ****************************************
  logic [7:0]  file_r [FILE_DEPTH];
  logic [7:0]  acc_r;
  logic        carry_r;
  logic        half_r;
  logic        zero_r;
  logic        skip_r;
  logic        cfg_presc_r;
  logic [6:0]  faddr_r;
  logic [13:0] last_op_r;
  logic [7:0]  pin_s1_r;
  logic [7:0]  pin_s2_r;
  logic        dph_act_r;
  logic        dph_wr_r;
  logic [7:0]  dph_addr_r;
  logic [31:0] hrdata_r;
  logic        hready_r;
  logic        presc_clr_r;

  alu_if a ();
  add_and_alu u_alu (.a(a));

  // ****************************************
  // bus slave decode
  // ****************************************
  // writes finish with no wait; reads take one wait so hrdata comes from a flop
  wire       addr_ok  = i_hsel & i_hready & (i_htrans == HTRANS_NONSEQ);
  wire       wr_go    = dph_act_r & dph_wr_r;
  wire       rd_go    = dph_act_r & ~dph_wr_r & ~hready_r;
  wire       issue    = wr_go & (dph_addr_r == OFS_INSTR);
  wire       go       = issue & ~skip_r;
  wire       wr_acc   = wr_go & (dph_addr_r == OFS_ACC);
  wire       wr_stat  = wr_go & (dph_addr_r == OFS_STATUS);
  wire       wr_faddr = wr_go & (dph_addr_r == OFS_FADDR);
  wire       wr_fdata = wr_go & (dph_addr_r == OFS_FDATA);
  wire       wr_cfg   = wr_go & (dph_addr_r == OFS_CFG);
  wire [3:0] stat_v   = {skip_r, zero_r, half_r, carry_r};
  wire [31:0] rd_mux  =
    (dph_addr_r == OFS_INSTR)  ? {18'h0_0000, last_op_r} :
    (dph_addr_r == OFS_ACC)    ? {24'h00_0000, acc_r} :
    (dph_addr_r == OFS_STATUS) ? {28'h000_0000, stat_v} :
    (dph_addr_r == OFS_FADDR)  ? {25'h000_0000, faddr_r} :
    (dph_addr_r == OFS_FDATA)  ? {24'h00_0000, file_r[faddr_r]} :
    (dph_addr_r == OFS_CFG)    ? {31'h0000_0000, cfg_presc_r} : 32'h0000_0000;

  // ****************************************
  // operand fetch
  // ****************************************
  // port reads see the pins, not the latch, so input pins write back their level
  wire [6:0] op_addr = i_hwdata[FADR_MSB:0];
  assign a.opcode  = i_hwdata[OPC_W-1:0];
  assign a.acc     = acc_r;
  assign a.operand = (op_addr == PORT_ADDR) ? pin_s2_r : file_r[op_addr];

  // bus phase tracking
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      dph_act_r  <= 1'b0;
      dph_wr_r   <= 1'b0;
      dph_addr_r <= RST_BYTE;
      hready_r   <= 1'b1;
      hrdata_r   <= 32'h0000_0000;
    end else begin
      dph_act_r <= addr_ok | (dph_act_r & ~(wr_go | rd_go));
      hready_r  <= ~(addr_ok & ~i_hwrite);
      if (addr_ok) begin
        dph_wr_r   <= i_hwrite;
        dph_addr_r <= i_haddr[7:0];
      end
      if (rd_go) hrdata_r <= rd_mux;
    end
  end

  // pin synchroniser, second stage is the only reader of the first
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      pin_s1_r <= RST_BYTE;
      pin_s2_r <= RST_BYTE;
    end else begin
      pin_s1_r <= i_port_pins;
      pin_s2_r <= pin_s1_r;
    end
  end

  // ****************************************
  // execute: results land at the end of the issue cycle
  // ****************************************
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      acc_r       <= RST_BYTE;
      carry_r     <= 1'b0;
      half_r      <= 1'b0;
      zero_r      <= 1'b0;
      skip_r      <= 1'b0;
      cfg_presc_r <= 1'b0;
      faddr_r     <= 7'h00;
      last_op_r   <= 14'h0000;
      presc_clr_r <= 1'b0;
    end else begin
      if (go && a.to_acc) acc_r <= a.result;
      else if (wr_acc) acc_r <= i_hwdata[7:0];
      if (go && a.upd_cz) begin
        carry_r <= a.carry;
        half_r  <= a.half_carry;
      end else if (wr_stat) begin
        carry_r <= i_hwdata[ST_CARRY];
        half_r  <= i_hwdata[ST_HALF];
      end
      if (go && a.upd_z) zero_r <= a.zero;
      else if (wr_stat) zero_r <= i_hwdata[ST_ZERO];
      // a pending skip eats exactly one issued instruction
      if (issue) skip_r <= ~skip_r & a.skip_taken;
      if (issue) last_op_r <= i_hwdata[OPC_W-1:0];
      if (wr_cfg) cfg_presc_r <= i_hwdata[CFG_PRESC_TMR];
      if (wr_faddr) faddr_r <= i_hwdata[FADR_MSB:0];
      presc_clr_r <= go & a.to_file & (op_addr == TIMER_ADDR) & cfg_presc_r;
    end
  end

  // file registers; an instruction write wins over a bus write, though they never coincide
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      for (int i = 0; i < FILE_DEPTH; i++) file_r[i] <= RST_BYTE;
    end else begin
      if (go && a.to_file) file_r[op_addr] <= a.result;
      else if (wr_fdata) file_r[faddr_r] <= i_hwdata[7:0];
    end
  end

  assign o_hrdata        = hrdata_r;
  assign o_hreadyout     = hready_r;
  assign o_hresp         = HRESP_OKAY;
  assign o_port_latch    = file_r[PORT_ADDR];
  assign o_prescaler_clr = presc_clr_r;
  assign o_skip_pending  = skip_r;

  // ****************************************
  // checks
  // ****************************************
  wire [7:0] chk_lit_sum = acc_r + i_hwdata[7:0];
  wire [7:0] chk_and     = acc_r & a.operand;
  wire [7:0] chk_fnew    = a.result;
  wire [7:0] chk_reg_sum = acc_r + a.operand;

  a_lit_add_sum: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
    go && a.kind[K_LIT_ADD] |=> acc_r == $past(chk_lit_sum))
    else $error("literal add sum wrong");
  a_reg_add_dest: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
    go && a.kind[K_REG_ADD] && i_hwdata[DEST_POS] |=> $stable(acc_r))
    else $error("register add to file changed accumulator");
  a_lit_and_flags: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
    go && a.kind[K_LIT_AND] |=> $stable(carry_r) && $stable(half_r))
    else $error("literal and touched carry");
  a_reg_and_zero: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
    go && a.kind[K_REG_AND] |=> zero_r == ($past(chk_and) == RST_BYTE))
    else $error("register and zero flag wrong");
  a_bit_ops_flags: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
    go && (a.kind[K_BCLR] || a.kind[K_BSET]) |=> $stable(stat_v[2:0]) && $stable(acc_r))
    else $error("bit op touched flags");
  a_bit_set_value: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
    go && a.kind[K_BSET] |=> file_r[$past(op_addr)][$past(a.opcode[BIDX_MSB:BIDX_LSB])])
    else $error("bit set result bit low");
  a_skip_clear: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
    go && a.kind[K_SCLR] |=> skip_r == !$past(a.bit_value))
    else $error("skip if clear decision wrong");
  a_skip_set: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
    go && a.kind[K_SSET] |=> skip_r == $past(a.bit_value))
    else $error("skip if set decision wrong");
  a_test_readonly: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
    go && (a.kind[K_SCLR] || a.kind[K_SSET]) |=> $stable(acc_r) && $stable(stat_v[2:0]))
    else $error("bit test modified state");
  a_skip_discard: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
    issue && skip_r |=> !skip_r && $stable(acc_r) && $stable(stat_v[2:0]))
    else $error("discarded instruction had effect");
  a_presc_clear: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
    go && a.to_file && op_addr == TIMER_ADDR && cfg_presc_r |=> o_prescaler_clr ##1 !o_prescaler_clr)
    else $error("prescaler clear missing");
  a_zero_flag: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
    go && a.upd_z |=> zero_r == ($past(chk_fnew) == RST_BYTE))
    else $error("zero flag mismatch");
  // landing values, checked against the operands of one cycle earlier
  a_bit_clr_value: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
    go && a.kind[K_BCLR] |=> !file_r[$past(op_addr)][$past(a.opcode[BIDX_MSB:BIDX_LSB])])
    else $error("bit clear result bit high");
  a_lit_and_value: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
    go && a.kind[K_LIT_AND] |=> acc_r == ($past(acc_r) & $past(a.opcode[7:0])))
    else $error("literal and result wrong");
  a_reg_add_acc: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
    go && a.kind[K_REG_ADD] && !a.opcode[DEST_POS] |=> acc_r == $past(chk_reg_sum))
    else $error("register add result late or wrong");
  a_presc_quiet: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
    !(go && a.to_file && op_addr == TIMER_ADDR && cfg_presc_r) |=> !o_prescaler_clr)
    else $error("spurious prescaler clear");
  // bus answer: a read always waits exactly one cycle, a write none
  a_read_wait: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
    addr_ok && !i_hwrite |=> !o_hreadyout ##1 o_hreadyout)
    else $error("read wait state wrong");

endmodule : add_and_bit_ops_datapath

// ### add_and_bit_ops_datapath_bench.sv
`timescale 1ns/1ns
module add_and_bit_ops_datapath_bench;
  import dp_pkg::*;
  logic        clk, arst_n, hsel, hwrite, hready, hresp, pclr, skip;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [7:0]  pins, latch, acc_m;
  logic [7:0]  file_m [FILE_DEPTH];
  logic        c_m, hc_m, z_m, skip_m;
  logic [6:0]  fa;
  logic [15:0] la [5];
  logic [15:0] pc [5];
  logic [13:0] ops [6];
  int          fail_count, n_compared, pclr_cnt, cyc, n;

  // hready loops back from the slave, as on a one-slave bus
  add_and_bit_ops_datapath i_dut (
    .i_clk_sys(clk), .i_arst_n(arst_n), .i_hsel(hsel), .i_haddr(haddr),
    .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata),
    .i_hready(hready), .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(hresp),
    .i_port_pins(pins), .o_port_latch(latch), .o_prescaler_clr(pclr),
    .o_skip_pending(skip));

  // clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // pulse counter and hang guard; the run needs under two thousand cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (pclr === 1'b1) pclr_cnt <= pclr_cnt + 1;
    if (cyc == 20000) begin
      fail_count++;
      results();
    end
  end

  // ****************************************
  // bus and model tasks
  // ****************************************
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // one single transfer; every wait ends only on a sampled hready
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel   <= 1'b1;
    haddr  <= {24'h00_0000, a};
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    rd = hrdata;
  endtask : xfer

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask : wr

  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0000_0000);
    chk(nm, e, rd);
  endtask : rdc

  task automatic setf(input logic [6:0] a, input logic [7:0] d);
    wr(OFS_FADDR, 32'(a));
    wr(OFS_FDATA, 32'(d));
    file_m[a] = d;
  endtask : setf

  task automatic set_st(input logic [7:0] a, input logic [2:0] fl);
    wr(OFS_ACC, 32'(a));
    wr(OFS_STATUS, 32'(fl));
    acc_m = a;
    {z_m, hc_m, c_m} = fl;
  endtask : set_st

  // port register is seen on the latch pins, others through the data window
  task automatic check_all(input logic [6:0] a);
    rdc("acc", OFS_ACC, 32'(acc_m));
    rdc("status", OFS_STATUS, 32'({skip_m, z_m, hc_m, c_m}));
    chk("skip", 32'(skip_m), 32'(skip));
    if (a == PORT_ADDR) begin
      chk("latch", 32'(file_m[a]), 32'(latch));
    end else begin
      wr(OFS_FADDR, 32'(a));
      rdc("file", OFS_FDATA, 32'(file_m[a]));
    end
  endtask : check_all

  // issue one opcode and move the reference state the same way
  task automatic issue(input logic [13:0] op);
    logic [7:0] f;
    logic [7:0] r;
    logic [8:0] s;
    logic [4:0] h;
    f = (op[6:0] == PORT_ADDR) ? pins : file_m[op[6:0]];
    r = op[13] ? op[7:0] : f;
    s = {1'b0, acc_m} + {1'b0, r};
    h = {1'b0, acc_m[3:0]} + {1'b0, r[3:0]};
    wr(OFS_INSTR, 32'(op));
    if (skip_m) begin
      skip_m = 1'b0;
    end else if (op[13:9] == PAT_LIT_ADD || op[13:8] == PAT_REG_ADD) begin
      {c_m, hc_m, z_m} = {s[8], h[4], s[7:0] == 8'h00};
      if (op[13] || !op[7]) acc_m = s[7:0];
      else file_m[op[6:0]] = s[7:0];
    end else if (op[13:8] == PAT_LIT_AND || op[13:8] == PAT_REG_AND) begin
      z_m = (acc_m & r) == 8'h00;
      if (op[13] || !op[7]) acc_m = acc_m & r;
      else file_m[op[6:0]] = acc_m & r;
    end else if (op[13:10] == PAT_BCLR) file_m[op[6:0]] = f & ~(8'h01 << op[9:7]);
    else if (op[13:10] == PAT_BSET) file_m[op[6:0]] = f | (8'h01 << op[9:7]);
    else if (op[13:10] == PAT_SCLR) skip_m = !f[op[9:7]];
    else if (op[13:10] == PAT_SSET) skip_m = f[op[9:7]];
  endtask : issue

  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : results

  // ****************************************
  // test sequence
  // ****************************************
  initial begin
    {arst_n, hsel, hwrite, htrans, haddr, hwdata, pins} = '0;
    hsize = 3'h2;
    {acc_m, c_m, hc_m, z_m, skip_m} = '0;
    foreach (file_m[i]) file_m[i] = 8'h00;
    la = '{16'hFF01, 16'h0808, 16'h7F80, 16'h0000, 16'h3C5A};
    ops = '{{PAT_LIT_ADD, 9'h000}, {PAT_LIT_AND, 8'h00}, {PAT_REG_ADD, 8'h00},
            {PAT_REG_ADD, 8'h80}, {PAT_REG_AND, 8'h00}, {PAT_REG_AND, 8'h80}};
    pc = '{{2'b11, PAT_BSET, 3'h0, TIMER_ADDR}, {2'b01, PAT_REG_ADD, 1'b0, TIMER_ADDR},
           {2'b01, PAT_SCLR, 3'h0, TIMER_ADDR}, {2'b11, PAT_REG_AND, 1'b1, TIMER_ADDR},
           {2'b00, PAT_BSET, 3'h2, TIMER_ADDR}};
    repeat (20) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    check_all(7'h00);
    rdc("cfg", OFS_CFG, 32'h0000_0000);
    rdc("last op", OFS_INSTR, 32'h0000_0000);
    chk("hresp", 32'(HRESP_OKAY), 32'(hresp));
    $display("test reset done");
    // carry, half carry and zero corners through every arithmetic form
    for (int k = 0; k < 6; k++) begin
      foreach (la[i]) begin
        fa = i[0] ? 7'h7F : 7'h00;
        setf(fa, la[i][7:0]);
        set_st(la[i][15:8], 3'h7);
        issue(ops[k] | (k < 2 ? 14'(la[i][7:0]) : 14'(fa)));
        check_all(fa);
      end
    end
    $display("test add and done");
    for (int b = 0; b < 8; b++) begin
      setf(7'h40, 8'h5A);
      set_st(8'h33, 3'h5);
      issue({PAT_BCLR, 3'(b), 7'h40});
      check_all(7'h40);
      issue({PAT_BSET, 3'(b), 7'h40});
      check_all(7'h40);
    end
    $display("test bit ops done");
    // both tests with both bit values; the follower is dropped only on a hit
    for (int t = 0; t < 4; t++) begin
      setf(7'h22, t[0] ? 8'h10 : 8'hEF);
      set_st(8'h01, 3'h0);
      issue({t[1] ? PAT_SSET : PAT_SCLR, 3'h4, 7'h22});
      check_all(7'h22);
      issue({PAT_LIT_ADD, 1'b0, 8'h01});
      check_all(7'h22);
      issue({PAT_LIT_ADD, 1'b0, 8'h02});
      check_all(7'h22);
    end
    $display("test skips done");
    setf(PORT_ADDR, 8'h0F);
    pins <= 8'hA5;
    repeat (4) @(posedge clk);
    issue({PAT_BSET, 3'h1, PORT_ADDR});
    check_all(PORT_ADDR);
    set_st(8'h01, 3'h0);
    issue({PAT_REG_ADD, 1'b1, PORT_ADDR});
    check_all(PORT_ADDR);
    $display("test port done");
    // only an executed write to the timer count, with the prescaler assigned, pulses
    foreach (pc[i]) begin
      wr(OFS_CFG, 32'(pc[i][14]));
      n = pclr_cnt;
      issue(pc[i][13:0]);
      repeat (2) @(posedge clk);
      chk("pclr", 32'(pc[i][15]), 32'(pclr_cnt - n));
    end
    $display("test prescaler done");
    wr(8'h18, 32'hFFFF_FFFF);
    rdc("unmapped", 8'h18, 32'h0000_0000);
    check_all(7'h22);
    rdc("faddr", OFS_FADDR, 32'h0000_0022);
    rdc("last op", OFS_INSTR, 32'(pc[4][13:0]));
    $display("test unmapped done");
    results();
  end
endmodule : add_and_bit_ops_datapath_bench
